// ===== pkg/vip_defs.svh
/*
 Constants for the vectored interrupt priority controller: register word indexes
 (byte address = 4 * index), field positions, reset values and source numbers.
 Assumes inclusion by both the package user and the controller.
*/
`ifndef VIP_DEFS_SVH
`define VIP_DEFS_SVH

// Register word indexes on the bus
`define VIP_WIDX_GC1   6'h00
`define VIP_WIDX_GC2   6'h01
`define VIP_WIDX_FLAG0 6'h02
`define VIP_WIDX_EN0   6'h07
`define VIP_WIDX_PRIO0 6'h0C
`define VIP_WIDX_PEND  6'h1E
`define VIP_WIDX_SR    6'h1F
`define VIP_WIDX_CORE  6'h20

// Sizes
`define VIP_NSRC  72
`define VIP_NFLAG 5
`define VIP_NPRIO 18

// Implemented request positions; reserved ones stay zero
`define VIP_IMPL 80'h00F6_21FF_DFFF_FFFB_7FFF

// Vector and table layout
`define VIP_VEC_OFS  7'h08
`define VIP_TBL_BASE 24'h000004
`define VIP_ALT_OFS  24'h000100
`define VIP_TRAP_LVL 4'h8

// Field positions and writable masks
`define VIP_NESTING_DISABLE_BIT 15
`define VIP_ALT_TABLE_SELECT_BIT 15
`define VIP_DIV0_BIT   6
`define VIP_GC1_WMASK  16'h807E
`define VIP_GC2_WMASK  16'h801F
`define VIP_GC_RST     16'h0000

// Source positions
`define VIP_IRQ_EXT0   0
`define VIP_IRQ_EXT1   20
`define VIP_IRQ_EXT2   29
`define VIP_IRQ_DMA4   46
`define VIP_IRQ_I2C2S  49
`define VIP_IRQ_I2C2M  50
`define VIP_IRQ_EXT3   53
`define VIP_IRQ_EXT4   54
`define VIP_IRQ_CAN2RX 55
`define VIP_IRQ_CAN2EV 56
`define VIP_IRQ_DMA5   61
`define VIP_IRQ_DMA6   68
`define VIP_IRQ_DMA7   69
`define VIP_IRQ_CAN1TX 70
`define VIP_IRQ_CAN2TX 71

// Bus answers
`define VIP_RESP_OK  2'b00
`define VIP_RESP_ERR 2'b10

`endif

// ===== pkg/vip_pkg.sv
/*
 Types shared by the interrupt controller and its users.
 Assumes nothing of its surroundings.
*/
package vip_pkg;

	// Requests from the sources that have named routes
	typedef struct packed {
		logic [3:0] dma_done;
		logic       i2c2_slave;
		logic       i2c2_master;
		logic       can2_rx;
		logic       can2_event;
		logic       can1_tx;
		logic       can2_tx;
	} vip_win_src_t;

	// Vector offered to the core
	typedef struct packed {
		logic        is_trap;
		logic [6:0]  vec_num;
		logic [3:0]  level;
		logic [23:0] addr;
	} vip_offer_t;

endpackage

// ===== rtl/vip_ctrl.sv
/*
 Vectored interrupt and trap controller with an AXI4-Lite register slave.
 Assumes request inputs synchronous to aclk, one-cycle or level requests,
 and a core that takes an offered vector with a one-cycle cpu_take.
*/
`timescale 1ns/1ps
`include "vip_defs.svh"

// What this block does
// - Vector is IRQ plus 8, two-byte entries, alternate entry 0x100 higher.
// - DMA channels four to seven complete on IRQ 46, 61, 68, 69.
// - Second I2C slave event on IRQ 49, master event on IRQ 50.
// - External pin three on IRQ 53, pin four on IRQ 54.
// - Second CAN receive-ready on IRQ 55, its event on IRQ 56.
// - CAN one and two transmit requests on IRQ 70 and 71.
// - Five non-maskable traps on vectors 1 to 5; 0, 6, 7 reserved.
// - Thirty-three registers: two control, five flag, five enable, eighteen priority, pending, status, core control.
// - Sources set flags; only software clears them.
// - A request arbitrates only while its enable bit is set.
// - Each source has a software priority of eight levels.
// - Accepting latches vector number and new level; level equals source priority, or 8 plus the trap number for a trap.
// - Flag, enable and priority positions follow IRQ order.
// - Low three level bits sit at status word bits 7 to 5.
// - Top level bit at core control bit 3; software cannot set it.
// - CPU level is top bit above the three low bits.
// - User interrupts blocked at level 7 or with top bit set.
// - Low level bits read-only while nesting is disabled.
// - Control one holds nesting disable and traps; two holds edges and table.
// - Alternate select bit 15 moves all vectors to the alternate table.
// - Pin polarity one requests on falling edge, zero on rising.
// - With nesting disabled, no interrupt preempts one in service.
module vip_ctrl
	import vip_pkg::*;
(
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [31:0]  awaddr,
	input  wire logic         awvalid,
	output logic              awready,
	input  wire logic [31:0]  wdata,
	input  wire logic [3:0]   wstrb,
	input  wire logic         wvalid,
	output logic              wready,
	output logic [1:0]        bresp,
	output logic              bvalid,
	input  wire logic         bready,
	input  wire logic [31:0]  araddr,
	input  wire logic         arvalid,
	output logic              arready,
	output logic [31:0]       rdata,
	output logic [1:0]        rresp,
	output logic              rvalid,
	input  wire logic         rready,
	input  wire logic [71:0]  periph_req,
	input  wire vip_win_src_t win_src,
	input  wire logic [4:0]   ext_pin,
	input  wire logic [5:1]   trap_req,
	input  wire logic         div0_err,
	output logic              irq_valid,
	output vip_offer_t        irq_offer,
	input  wire logic         cpu_take,
	input  wire logic         cpu_return,
	input  wire logic [3:0]   cpu_ret_level,
	output logic [3:0]        cpu_level
);

	logic                awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic                aw_got_r, w_got_r;
	logic [31:0]         aw_addr_r, rdata_r;
	logic [15:0]         w_data_r;
	logic [1:0]          w_strb_r, bresp_r, rresp_r;
	logic [15:0]         gc1_r, gc2_r, gc1_nxt, gc2_nxt;
	logic [79:0]         flag_r, en_r, flag_nxt, en_nxt;
	logic [2:0]          prio_r [`VIP_NSRC];
	logic [3:0]          lvl_r;
	logic                in_service_r;
	logic [6:0]          pend_vec_r;
	logic [3:0]          pend_lvl_r;
	logic [5:1]          trap_pend_r;
	logic [4:0]          ext_prev_r, ext_edge;
	logic [71:0]         raw;
	logic                irq_valid_r;
	vip_offer_t          irq_offer_r;
	logic                wr_do, wr_ok, take, nesting_disable;
	logic [5:0]          wr_idx, ar_idx;
	logic [15:0]         wm, wd, rd_val;
	logic                rd_hit;
	logic                found, trap_found;
	logic [6:0]          best_irq;
	logic [2:0]          best_p, trap_n;

	assign awready   = awready_r;
	assign wready    = wready_r;
	assign bvalid    = bvalid_r;
	assign bresp     = bresp_r;
	assign arready   = arready_r;
	assign rvalid    = rvalid_r;
	assign rdata     = rdata_r;
	assign rresp     = rresp_r;
	assign irq_valid = irq_valid_r;
	assign irq_offer = irq_offer_r;
	assign cpu_level = lvl_r;

	// Shared decode of the held write and of the incoming read
	assign wr_do  = aw_got_r && w_got_r && !bvalid_r;
	assign wr_idx = aw_addr_r[7:2];
	assign wr_ok  = (aw_addr_r[31:8] == 24'h000000) && (wr_idx <= `VIP_WIDX_CORE);
	assign wm     = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
	assign wd     = w_data_r;
	assign ar_idx = araddr[7:2];
	assign take   = irq_valid_r && cpu_take;
	assign nesting_disable = gc1_r[`VIP_NESTING_DISABLE_BIT];

	// Write channels: address and data taken in either order, answer after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `VIP_RESP_OK;
			aw_addr_r <= 32'h00000000;
			w_data_r  <= 16'h0000;
			w_strb_r  <= 2'b00;
		end else begin
			if (awvalid && awready_r) begin
				aw_got_r  <= 1'b1;
				awready_r <= 1'b0;
				aw_addr_r <= awaddr;
			end
			if (wvalid && wready_r) begin
				w_got_r  <= 1'b1;
				wready_r <= 1'b0;
				w_data_r <= wdata[15:0];
				w_strb_r <= wstrb[1:0];  // Upper lanes hold no bits
			end
			if (wr_do) begin
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r  <= wr_ok ? `VIP_RESP_OK : `VIP_RESP_ERR;
			end
			if (bvalid_r && bready) begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	// Read mux on address bits 7:2; unmapped words answer an error, reading zero only past index 0x20
	always_comb begin
		rd_val = 16'h0000;
		rd_hit = (araddr[31:8] == 24'h000000) && (ar_idx <= `VIP_WIDX_CORE);
		case (ar_idx)
			`VIP_WIDX_GC1:  rd_val = gc1_r;
			`VIP_WIDX_GC2:  rd_val = gc2_r;
			`VIP_WIDX_PEND: rd_val = {4'h0, pend_lvl_r, 1'b0, pend_vec_r};
			`VIP_WIDX_SR:   rd_val = {8'h00, lvl_r[2:0], 5'h00};
			`VIP_WIDX_CORE: rd_val = {12'h000, lvl_r[3], 3'h0};
			default:        rd_val = 16'h0000;
		endcase
		for (int k = 0; k < `VIP_NFLAG; k++) begin
			if (ar_idx == 6'(`VIP_WIDX_FLAG0 + k))
				rd_val = flag_r[16*k +: 16];
			if (ar_idx == 6'(`VIP_WIDX_EN0 + k))
				rd_val = en_r[16*k +: 16];
		end
		for (int k = 0; k < `VIP_NPRIO; k++) begin
			if (ar_idx == 6'(`VIP_WIDX_PRIO0 + k)) begin
				for (int j = 0; j < 4; j++)
					rd_val[4*j +: 3] = prio_r[4*k + j];
			end
		end
	end

	// Read channel answers one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= `VIP_RESP_OK;
		end else if (arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rdata_r   <= {16'h0000, rd_val};
			rresp_r   <= rd_hit ? `VIP_RESP_OK : `VIP_RESP_ERR;
		end else if (rvalid_r && rready) begin
			rvalid_r  <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	// Pin edges; the polarity bit picks which edge counts
	assign ext_edge = (gc2_r[4:0] & ext_prev_r & ~ext_pin) | (~gc2_r[4:0] & ~ext_prev_r & ext_pin);

	always_ff @(posedge aclk) begin
		if (!aresetn)
			ext_prev_r <= 5'h00;
		else
			ext_prev_r <= ext_pin;
	end

	// Route every source to its request position
	always_comb begin
		raw                  = periph_req & 72'(`VIP_IMPL);
		raw[`VIP_IRQ_EXT0]   = ext_edge[0];
		raw[`VIP_IRQ_EXT1]   = ext_edge[1];
		raw[`VIP_IRQ_EXT2]   = ext_edge[2];
		raw[`VIP_IRQ_EXT3]   = ext_edge[3];
		raw[`VIP_IRQ_EXT4]   = ext_edge[4];
		raw[`VIP_IRQ_DMA4]   = win_src.dma_done[0];
		raw[`VIP_IRQ_DMA5]   = win_src.dma_done[1];
		raw[`VIP_IRQ_DMA6]   = win_src.dma_done[2];
		raw[`VIP_IRQ_DMA7]   = win_src.dma_done[3];
		raw[`VIP_IRQ_I2C2S]  = win_src.i2c2_slave;
		raw[`VIP_IRQ_I2C2M]  = win_src.i2c2_master;
		raw[`VIP_IRQ_CAN2RX] = win_src.can2_rx;
		raw[`VIP_IRQ_CAN2EV] = win_src.can2_event;
		raw[`VIP_IRQ_CAN1TX] = win_src.can1_tx;
		raw[`VIP_IRQ_CAN2TX] = win_src.can2_tx;
	end

	// Flags and enables; a source set in the clearing cycle wins
	always_comb begin
		flag_nxt = flag_r;
		en_nxt   = en_r;
		for (int k = 0; k < `VIP_NFLAG; k++) begin
			if (wr_do && wr_idx == 6'(`VIP_WIDX_FLAG0 + k))
				flag_nxt[16*k +: 16] = (flag_r[16*k +: 16] & ~wm) | (wd & wm);
			if (wr_do && wr_idx == 6'(`VIP_WIDX_EN0 + k))
				en_nxt[16*k +: 16] = (en_r[16*k +: 16] & ~wm) | (wd & wm);
		end
		flag_nxt = (flag_nxt | {8'h00, raw}) & `VIP_IMPL;
		en_nxt   = en_nxt & `VIP_IMPL;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_r <= 80'h0;
			en_r   <= 80'h0;
		end else begin
			flag_r <= flag_nxt;
			en_r   <= en_nxt;
		end
	end

	// Priority fields, four per word, in IRQ order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < `VIP_NSRC; i++)
				prio_r[i] <= 3'h0;
		end else if (wr_do) begin
			for (int i = 0; i < `VIP_NSRC; i++) begin
				if (wr_idx == 6'(`VIP_WIDX_PRIO0 + i / 4) && w_strb_r[(i % 4) / 2])
					prio_r[i] <= wd[4*(i % 4) +: 3];
			end
		end
	end

	// Global controls; trap status sets override a software clear
	always_comb begin
		gc1_nxt = gc1_r;
		gc2_nxt = gc2_r;
		if (wr_do && wr_idx == `VIP_WIDX_GC1)
			gc1_nxt = (gc1_r & ~(wm & `VIP_GC1_WMASK)) | (wd & wm & `VIP_GC1_WMASK);
		if (wr_do && wr_idx == `VIP_WIDX_GC2)
			gc2_nxt = (gc2_r & ~(wm & `VIP_GC2_WMASK)) | (wd & wm & `VIP_GC2_WMASK);
		gc1_nxt[5:1]           = gc1_nxt[5:1] | trap_req;
		gc1_nxt[`VIP_DIV0_BIT] = gc1_nxt[`VIP_DIV0_BIT] | div0_err;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gc1_r <= `VIP_GC_RST;
			gc2_r <= `VIP_GC_RST;
		end else begin
			gc1_r <= gc1_nxt;
			gc2_r <= gc2_nxt;
		end
	end

	// Trap pending bits are separate from status so a taken trap does not refire
	always_ff @(posedge aclk) begin
		if (!aresetn)
			trap_pend_r <= 5'h00;
		else begin
			for (int n = 1; n <= 5; n++) begin
				if (take && irq_offer_r.is_trap && irq_offer_r.vec_num == 7'(n))
					trap_pend_r[n] <= trap_req[n];
				else
					trap_pend_r[n] <= trap_pend_r[n] | trap_req[n];
			end
		end
	end

	// Arbitration; scanning downward with >= lets the lower IRQ win ties
	always_comb begin
		found      = 1'b0;
		best_p     = 3'h0;
		best_irq   = 7'h00;
		trap_found = 1'b0;
		trap_n     = 3'h0;
		for (int i = `VIP_NSRC - 1; i >= 0; i--) begin
			if (flag_r[i] && en_r[i] && ({1'b0, prio_r[i]} > lvl_r) &&
					!(nesting_disable && in_service_r) && (!found || prio_r[i] >= best_p)) begin
				found    = 1'b1;
				best_p   = prio_r[i];
				best_irq = 7'(i);
			end
		end
		for (int n = 5; n >= 1; n--) begin
			if (trap_pend_r[n]) begin
				trap_found = 1'b1;
				trap_n     = 3'(n);
			end
		end
	end

	// Table address of a vector, primary or alternate
	function automatic logic [23:0] vec_addr(input logic [6:0] v, input logic alt);
		vec_addr = `VIP_TBL_BASE + {16'h0000, v, 1'b0} + (alt ? `VIP_ALT_OFS : 24'h000000);
	endfunction

	// Offer to the core; held stable until taken, traps ahead of interrupts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_valid_r <= 1'b0;
			irq_offer_r <= '0;
		end else if (irq_valid_r) begin
			if (cpu_take)
				irq_valid_r <= 1'b0;
		end else if (trap_found) begin
			irq_valid_r         <= 1'b1;
			irq_offer_r.is_trap <= 1'b1;
			irq_offer_r.vec_num <= {4'h0, trap_n};
			irq_offer_r.level   <= `VIP_TRAP_LVL + {1'b0, trap_n};
			irq_offer_r.addr    <= vec_addr({4'h0, trap_n}, gc2_r[`VIP_ALT_TABLE_SELECT_BIT]);
		end else if (found) begin
			irq_valid_r         <= 1'b1;
			irq_offer_r.is_trap <= 1'b0;
			irq_offer_r.vec_num <= best_irq + `VIP_VEC_OFS;
			irq_offer_r.level   <= {1'b0, best_p};
			irq_offer_r.addr    <= vec_addr(best_irq + `VIP_VEC_OFS, gc2_r[`VIP_ALT_TABLE_SELECT_BIT]);
		end
	end

	// Pending-vector word latched at acceptance
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_vec_r <= 7'h00;
			pend_lvl_r <= 4'h0;
		end else if (take) begin
			pend_vec_r <= irq_offer_r.vec_num;
			pend_lvl_r <= irq_offer_r.level;
		end
	end

	// CPU level; top bit set only by traps or a return level, software may only clear it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lvl_r        <= 4'h0;
			in_service_r <= 1'b0;
		end else if (take) begin
			lvl_r        <= irq_offer_r.level;
			in_service_r <= in_service_r | !irq_offer_r.is_trap;
		end else if (cpu_return) begin
			lvl_r        <= cpu_ret_level;
			in_service_r <= 1'b0;
		end else if (wr_do && w_strb_r[0]) begin
			if (wr_idx == `VIP_WIDX_SR && !nesting_disable)
				lvl_r[2:0] <= wd[7:5];
			if (wr_idx == `VIP_WIDX_CORE)
				lvl_r[3] <= lvl_r[3] & wd[3];
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_wr_both;
		aw_got_r && w_got_r && !bvalid_r;
	endsequence

	sequence s_idle_blocked;
		!irq_valid_r && !trap_found;
	endsequence

	a_dma4_route: assert property (win_src.dma_done[0] |=> flag_r[`VIP_IRQ_DMA4])
		else $error("DMA4 request did not set its flag");
	a_flag_sticky: assert property (flag_r[`VIP_IRQ_DMA4] && !(wr_do && wr_idx == 6'h04)
			|=> flag_r[`VIP_IRQ_DMA4])
		else $error("Flag cleared without software write");
	a_ext3_fall: assert property (gc2_r[3] && ext_prev_r[3] && !ext_pin[3] |=> flag_r[`VIP_IRQ_EXT3])
		else $error("Falling edge on pin three missed");
	a_offer_addr: assert property (irq_valid_r |-> irq_offer_r.addr == `VIP_TBL_BASE
			+ {16'h0000, irq_offer_r.vec_num, 1'b0} + (gc2_r[15] ? `VIP_ALT_OFS : 24'h0))
		else $error("Vector address does not match table");
	a_level_latch: assert property (take && !irq_offer_r.is_trap |=> pend_lvl_r == $past(irq_offer_r.level)
			&& lvl_r == pend_lvl_r && pend_vec_r == $past(irq_offer_r.vec_num))
		else $error("Pending word or level not latched");
	a_level_block: assert property (s_idle_blocked ##0 lvl_r >= 4'h7 |=> !irq_valid_r)
		else $error("User interrupt offered at level 7 or above");
	a_top_no_set: assert property (!lvl_r[3] && !take && !cpu_return |=> !lvl_r[3])
		else $error("Top level bit set by software");
	a_sr_readonly: assert property (nesting_disable && !take && !cpu_return |=> lvl_r[2:0] == $past(lvl_r[2:0]))
		else $error("Level bits written while nesting disabled");
	a_no_preempt: assert property (s_idle_blocked ##0 nesting_disable && in_service_r |=> !irq_valid_r)
		else $error("Preemption with nesting disabled");
	a_reserved_zero: assert property ((flag_r & ~`VIP_IMPL) == 80'h0 && (en_r & ~`VIP_IMPL) == 80'h0)
		else $error("Reserved position holds a bit");
	a_write_answer: assert property (s_wr_both |=> bvalid_r)
		else $error("Write not answered");

endmodule

// ===== verif/test_vip_ctrl.sv
/*
 Self-checking bench for the interrupt controller: bus tasks, a core model
 and one task per scenario. Assumes the word map of the controller's header.
*/
`timescale 1ns/1ps
`include "vip_defs.svh"

module test_vip_ctrl
	import vip_pkg::*;
;
	logic         aclk = 1'b0;
	logic         aresetn = 1'b0;
	logic [31:0]  awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
	logic [3:0]   wstrb = 4'hF, take_delay = 4'h0, ret_lvl = 4'h0, cpu_level;
	logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic         cpu_ret = 1'b0, div0 = 1'b0;
	logic         awready, wready, bvalid, arready, rvalid, irq_valid, cpu_take;
	logic [1:0]   bresp, rresp;
	logic [71:0]  preq = 72'h0;
	vip_win_src_t wsrc = '0;
	logic [4:0]   ext = 5'h00;
	logic [5:1]   trap = 5'h00;
	vip_offer_t   offer, got;
	logic [7:0]   n_taken;
	int           miscompares = 0, n_tests = 0, cyc = 0;

	vip_ctrl u_vip_ctrl (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .periph_req(preq), .win_src(wsrc), .ext_pin(ext), .trap_req(trap),
		.div0_err(div0), .irq_valid(irq_valid), .irq_offer(offer), .cpu_take(cpu_take),
		.cpu_return(cpu_ret), .cpu_ret_level(ret_lvl), .cpu_level(cpu_level));

	vip_core_model u_vip_core_model (.aclk(aclk), .aresetn(aresetn), .irq_valid(irq_valid), .irq_offer(offer),
		.take_delay(take_delay), .cpu_take(cpu_take), .taken_offer(got), .n_taken(n_taken));

	// Clock and a watchdog that turns a hang into a failure
	always #12.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			finish_test();
		end
	end

	task finish_test;
		if (miscompares == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk_offer(input vip_offer_t g, input vip_offer_t e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("Error at %0t: offer %h expected %h", $time, g, e);
		end
	endtask

	// Write one word; address and data offered together, each released when taken
	task automatic wr(input logic [5:0] i, input logic [15:0] d);
		bit a;
		bit w;
		a = 0;
		w = 0;
		awaddr <= {24'h0, i, 2'b00};
		wdata <= {16'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(a && w)) begin
			@(posedge aclk);
			if (!a && awready) begin
				a = 1;
				awvalid <= 1'b0;
			end
			if (!w && wready) begin
				w = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		chk_val(bresp, (i > 6'h20) ? `VIP_RESP_ERR : `VIP_RESP_OK);
	endtask

	// Read one word; unmapped places answer zero with an error
	task automatic chk_rd(input logic [5:0] i, input logic [15:0] e);
		araddr <= {24'h0, i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		chk_val(rdata, {16'h0, e});
		chk_val(rresp, (i > 6'h20) ? `VIP_RESP_ERR : `VIP_RESP_OK);
	endtask

	task automatic pulse_req(input logic [71:0] m);
		preq <= m;
		@(posedge aclk);
		preq <= 72'h0;
	endtask

	task automatic pulse_win(input vip_win_src_t m);
		wsrc <= m;
		@(posedge aclk);
		wsrc <= '0;
	endtask

	// Bounded wait for the core to have taken n offers
	task automatic wait_take(input logic [7:0] n);
		for (int k = 0; k < 40 && n_taken !== n; k++)
			@(posedge aclk);
		chk_val(n_taken, n);
	endtask

	// Nothing may be offered for a while
	task automatic quiet(input logic [7:0] n);
		repeat (12) @(posedge aclk);
		chk_val(n_taken, n);
		chk_val(irq_valid, 1'b0);
	endtask

	task automatic ret(input logic [3:0] l);
		ret_lvl <= l;
		cpu_ret <= 1'b1;
		@(posedge aclk);
		cpu_ret <= 1'b0;
	endtask

	task t_reset;
		chk_rd(6'h00, 16'h0000);
		chk_rd(6'h1E, 16'h0000);
		chk_rd(6'h20, 16'h0000);
		chk_val(cpu_level, 4'h0);
		chk_rd(6'h21, 16'h0000);
		wr(6'h21, 16'hFFFF);
	endtask

	task t_basic;
		take_delay <= 4'h3;
		wr(6'h0C, 16'h5000);
		wr(6'h07, 16'h0008);
		pulse_req(72'h8);
		wait_take(8'h01);
		chk_offer(got, vip_offer_t'{1'b0, 7'h0B, 4'h5, 24'h00001A});
		chk_rd(6'h1E, 16'h050B);
		chk_val(cpu_level, 4'h5);
		chk_rd(6'h02, 16'h0008);
		wr(6'h02, 16'h0000);
		chk_rd(6'h02, 16'h0000);
		wr(6'h07, 16'h0000);
		take_delay <= 4'h0;
		ret(4'h0);
	endtask

	task t_arb;
		wr(6'h0C, 16'h4040);
		wr(6'h0E, 16'h0060);
		wr(6'h07, 16'h020A);
		pulse_req(72'h20A);
		wait_take(8'h02);
		chk_offer(got, vip_offer_t'{1'b0, 7'h11, 4'h6, 24'h000026});
		wr(6'h02, 16'h000A);
		ret(4'h0);
		wait_take(8'h03);
		chk_offer(got, vip_offer_t'{1'b0, 7'h09, 4'h4, 24'h000016});
		wr(6'h02, 16'h0000);
		wr(6'h07, 16'h0000);
		ret(4'h0);
	endtask

	task automatic t_routes;
		int tab[6] = '{49, 50, 55, 56, 70, 71};
		pulse_win(vip_win_src_t'(10'h3C0));
		chk_rd(6'h04, 16'h4000);
		chk_rd(6'h05, 16'h2000);
		chk_rd(6'h06, 16'h0030);
		wr(6'h04, 16'h0000);
		wr(6'h06, 16'h0000);
		wr(6'h05, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			pulse_win(vip_win_src_t'(10'h020 >> i));
			chk_rd(6'(2 + tab[i] / 16), 16'h0001 << (tab[i] % 16));
			wr(6'(2 + tab[i] / 16), 16'h0000);
		end
	endtask

	task t_pins;
		wr(6'h01, 16'h0008);
		ext <= 5'h18;
		repeat (2) @(posedge aclk);
		chk_rd(6'h05, 16'h0040);
		ext <= 5'h00;
		repeat (2) @(posedge aclk);
		chk_rd(6'h05, 16'h0060);
		wr(6'h05, 16'h0000);
		wr(6'h01, 16'h0000);
	endtask

	task t_trap;
		wr(6'h01, 16'h8000);
		trap <= 5'h11;
		div0 <= 1'b1;
		@(posedge aclk);
		trap <= 5'h00;
		div0 <= 1'b0;
		wait_take(8'h04);
		chk_offer(got, vip_offer_t'{1'b1, 7'h01, 4'h9, 24'h000106});
		wait_take(8'h05);
		chk_offer(got, vip_offer_t'{1'b1, 7'h05, 4'hD, 24'h00010E});
		chk_rd(6'h00, 16'h0062);
		chk_val(cpu_level, 4'hD);
		chk_rd(6'h20, 16'h0008);
		wr(6'h20, 16'h0000);
		chk_val(cpu_level, 4'h5);
		chk_rd(6'h1F, 16'h00A0);
		wr(6'h20, 16'h0008);
		chk_rd(6'h20, 16'h0000);
		wr(6'h00, 16'h0000);
		wr(6'h01, 16'h0000);
	endtask

	task t_mask;
		wr(6'h0C, 16'h7000);
		pulse_req(72'h8);
		quiet(8'h05);
		wr(6'h1F, 16'h00E0);
		chk_val(cpu_level, 4'h7);
		wr(6'h07, 16'h0008);
		quiet(8'h05);
		wr(6'h1F, 16'h00C0);
		wait_take(8'h06);
		chk_offer(got, vip_offer_t'{1'b0, 7'h0B, 4'h7, 24'h00001A});
		wr(6'h02, 16'h0000);
		wr(6'h07, 16'h0000);
		ret(4'h0);
	endtask

	task t_nest;
		wr(6'h00, 16'h8000);
		wr(6'h1F, 16'h00A0);
		chk_rd(6'h1F, 16'h0000);
		wr(6'h0C, 16'h5000);
		wr(6'h07, 16'h0208);
		pulse_req(72'h8);
		wait_take(8'h07);
		pulse_req(72'h200);
		quiet(8'h07);
		ret(4'h0);
		wait_take(8'h08);
		chk_offer(got, vip_offer_t'{1'b0, 7'h11, 4'h6, 24'h000026});
		wr(6'h02, 16'h0000);
		wr(6'h07, 16'h0000);
		wr(6'h00, 16'h0000);
		ret(4'h0);
	endtask

	task t_reserved;
		wr(6'h06, 16'hFFFF);
		chk_rd(6'h06, 16'h00F6);
		wr(6'h06, 16'h0000);
		wr(6'h1D, 16'hFFFF);
		chk_rd(6'h1D, 16'h7777);
		wr(6'h1D, 16'h0000);
	endtask

	// Reset, then the scenarios in an order that leaves the level at zero between them, except 5 after t_trap
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_basic();
		t_arb();
		t_routes();
		t_pins();
		t_trap();
		t_mask();
		t_nest();
		t_reserved();
		finish_test();
	end
endmodule

// ===== verif/vip_core_model.sv
/*
 Behavioural model of the CPU core that takes offered vectors.
 Assumes the controller holds irq_valid and irq_offer until cpu_take is seen.
*/
`timescale 1ns/1ps

module vip_core_model
	import vip_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       irq_valid,
	input  wire vip_offer_t irq_offer,
	input  wire logic [3:0] take_delay,
	output logic            cpu_take,
	output vip_offer_t      taken_offer,
	output logic [7:0]      n_taken
);
	logic [3:0] wait_r;

	// Take after a chosen delay, so slow acceptance is exercised too
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpu_take <= 1'b0;
			wait_r <= 4'h0;
		end else begin
			cpu_take <= irq_valid && !cpu_take && (wait_r >= take_delay);
			wait_r <= (irq_valid && !cpu_take) ? wait_r + 4'h1 : 4'h0;
		end
	end

	// Record what was accepted at the taking edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			taken_offer <= '0;
			n_taken <= 8'h00;
		end else if (irq_valid && cpu_take) begin
			taken_offer <= irq_offer;
			n_taken <= n_taken + 8'h01;
		end
	end
endmodule
